/* febp_pkg.sv */
/*
 * Package for the flash erase, bank select and posted write controller.
 * Assumes an SFR port driven by the core, synchronous to clk.
 */
//
// Behaviour
// - Addresses 0x0000 to 0x7fff always reach the fixed lower 32 KB bank.
// - Addresses 0x8000 to 0xffff reach the bank picked by the two-bit bank select, reset to one.
// - With bank select zero the upper window reaches the lower bank's memory.
// - Writing 0x55 to the erase command starts a page erase of the page set beforehand.
// - Writing 0xaa starts a mass erase only if mass erase was enabled and debug is on.
// - Other erase command values do nothing; the register is write-only and resets to 0x00.
// - The mass erase enable is used up by any 0xaa command, whether it erases or not, and must be set again.
// - The six-bit page number picks page 0 to 63 and must be written before each page erase.
// - With posted writes and the compute engine enabled, one write waits until busy falls.
// - With posted writes or the compute engine disabled, writes go out at once.
// - A pending flag shows a queued write, and writes arriving meanwhile are dropped.
// - With program write enable set, a data store writes the byte to flash and clears the bit.
// - Program write enable cannot be written while interrupts are enabled.
// - No erase or data store is accepted unless the unlock key holds 2; a queued write drains without a key check.
package febp_pkg;
    localparam logic [7:0] FEBP_ERASE_CMD_ADDR  = 8'h94;
    localparam logic [7:0] FEBP_FLASH_CTL_ADDR  = 8'hb2;
    localparam logic [7:0] FEBP_BANK_ADDR       = 8'hb6;
    localparam logic [7:0] FEBP_PAGE_ADDR       = 8'hb7;
    localparam int         FEBP_PWE_BIT         = 0;
    localparam int         FEBP_MEEN_BIT        = 1;
    localparam int         FEBP_PSTWR_BIT       = 2;
    localparam int         FEBP_PEND_BIT        = 3;
    localparam int         FEBP_PAGE_LSB        = 2;
    localparam logic [7:0] FEBP_CMD_PAGE_ERASE  = 8'h55;
    localparam logic [7:0] FEBP_CMD_MASS_ERASE  = 8'haa;
    localparam logic [7:0] FEBP_CMD_RESET       = 8'h00;
    localparam logic [1:0] FEBP_BANK_RESET      = 2'h1;
    localparam logic [5:0] FEBP_PAGE_RESET      = 6'h00;
    localparam logic [3:0] FEBP_UNLOCK_KEY      = 4'h2;
endpackage : febp_pkg

/* febp_write_queue.sv */
/*
 * One-entry holding slot for a posted flash byte write.
 * Assumes busy from the compute engine is synchronous to clk.
 */
`timescale 1ns/1ps
module febp_write_queue #(
    parameter int AW = 17
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          push,
    input  wire logic [AW-1:0] push_addr,
    input  wire logic [7:0]    push_data,
    input  wire logic          drain,
    output logic               full_q,
    output logic [AW-1:0]      addr_q,
    output logic [7:0]         data_q
);
    // Hold the entry; drain and push never coincide since push needs empty
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            full_q <= 1'b0;
            addr_q <= '0;
            data_q <= 8'h00;
        end else if (push && !full_q) begin
            full_q <= 1'b1;
            addr_q <= push_addr;
            data_q <= push_data;
        end else if (drain) begin
            full_q <= 1'b0;
        end
    end
endmodule : febp_write_queue

/* febp_ctrl.sv */
/*
 * Flash controller: bank mapping, keyed erase start, posted byte writes.
 * Assumes an SFR write/read strobe port from the core, a flash array
 * that takes one-cycle erase and write pulses, and compute engine signals.
 */
`timescale 1ns/1ps
module febp_ctrl
    import febp_pkg::*;
#(
    parameter int AW = 17
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic [7:0]       sfr_rdata_q,
    input  wire logic        irq_global_en,
    input  wire logic        debug_port_en,
    input  wire logic [3:0]  flash_unlock_key,
    input  wire logic [15:0] prog_addr,
    output logic [AW-1:0]    flash_addr_q,
    input  wire logic        xdata_store,
    input  wire logic [15:0] xdata_ptr,
    input  wire logic [7:0]  xdata_acc,
    input  wire logic        ce_enable,
    input  wire logic        ce_busy,
    output logic             flash_wr_q,
    output logic [AW-1:0]    flash_wr_addr_q,
    output logic [7:0]       flash_wr_data_q,
    output logic             page_erase_q,
    output logic             mass_erase_q,
    output logic [5:0]       erase_page_q,
    output logic             program_write_enable_q,
    output logic             posted_write_pending_q
);
    import febp_pkg::*;

    logic [1:0]    upper_bank_select_q;
    logic [5:0]    erase_page_number_q;
    logic          page_valid_q;
    logic          mass_erase_enable_q;
    logic          posted_write_enable_q;
    logic          ce_busy_q;
    logic          unlocked;
    logic          wr_ctl;
    logic          wr_cmd;
    logic          flash_store;
    logic          post_mode;
    logic          busy_fall;
    logic          q_full;
    logic [AW-1:0] q_addr;
    logic [7:0]    q_data;
    logic [AW-1:0] store_addr;

    assign unlocked    = (flash_unlock_key == FEBP_UNLOCK_KEY);
    assign wr_ctl      = sfr_wr && (sfr_addr == FEBP_FLASH_CTL_ADDR);
    assign wr_cmd      = sfr_wr && (sfr_addr == FEBP_ERASE_CMD_ADDR);
    assign flash_store = xdata_store && program_write_enable_q && unlocked;
    assign post_mode   = posted_write_enable_q && ce_enable;
    assign busy_fall   = ce_busy_q && !ce_busy;

    // Map a program or data-pointer address onto the physical array
    function automatic logic [AW-1:0] febp_map(input logic [15:0] a, input logic [1:0] bank);
        logic [AW-1:0] r;
        r = '0;
        if (!a[15] || bank == 2'h0) begin
            r[14:0] = a[14:0];
        end else begin
            r = AW'({bank, a[14:0]});
        end
        return r;
    endfunction : febp_map

    assign store_addr = febp_map(xdata_ptr, upper_bank_select_q);

    // Bank select register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            upper_bank_select_q <= FEBP_BANK_RESET;
        end else if (sfr_wr && sfr_addr == FEBP_BANK_ADDR) begin
            upper_bank_select_q <= sfr_wdata[1:0];
        end
    end

    // Registered program fetch address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_addr_q <= '0;
        end else begin
            flash_addr_q <= febp_map(prog_addr, upper_bank_select_q);
        end
    end

    // Page number, armed by each write and used up by each page erase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            erase_page_number_q <= FEBP_PAGE_RESET;
            page_valid_q        <= 1'b0;
        end else if (sfr_wr && sfr_addr == FEBP_PAGE_ADDR) begin
            erase_page_number_q <= sfr_wdata[7:FEBP_PAGE_LSB];
            page_valid_q        <= 1'b1;
        end else if (wr_cmd && sfr_wdata == FEBP_CMD_PAGE_ERASE) begin
            page_valid_q        <= 1'b0;
        end
    end

    // Mass erase enable, consumed by any mass erase command
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mass_erase_enable_q <= 1'b0;
        end else if (wr_ctl) begin
            mass_erase_enable_q <= sfr_wdata[FEBP_MEEN_BIT];
        end else if (wr_cmd && sfr_wdata == FEBP_CMD_MASS_ERASE) begin
            mass_erase_enable_q <= 1'b0;
        end
    end

    // Posted write enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            posted_write_enable_q <= 1'b0;
        end else if (wr_ctl) begin
            posted_write_enable_q <= sfr_wdata[FEBP_PSTWR_BIT];
        end
    end

    // Program write enable; self clears after any data store, unlocked or not
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            program_write_enable_q <= 1'b0;
        end else if (wr_ctl && !irq_global_en) begin
            program_write_enable_q <= sfr_wdata[FEBP_PWE_BIT];
        end else if (xdata_store && program_write_enable_q) begin
            program_write_enable_q <= 1'b0;
        end
    end

    // Erase start pulses, only for the two keyed patterns
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page_erase_q <= 1'b0;
            mass_erase_q <= 1'b0;
            erase_page_q <= FEBP_PAGE_RESET;
        end else begin
            page_erase_q <= wr_cmd && sfr_wdata == FEBP_CMD_PAGE_ERASE
                            && page_valid_q && unlocked;
            mass_erase_q <= wr_cmd && sfr_wdata == FEBP_CMD_MASS_ERASE
                            && mass_erase_enable_q && debug_port_en && unlocked;
            erase_page_q <= erase_page_number_q;
        end
    end

    // Busy edge detector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_busy_q <= 1'b0;
        end else begin
            ce_busy_q <= ce_busy;
        end
    end

    febp_write_queue #(
        .AW (AW)
    ) u_queue (
        .clk       (clk),
        .rst_b     (rst_b),
        .push      (flash_store && post_mode && !q_full),
        .push_addr (store_addr),
        .push_data (xdata_acc),
        .drain     (q_full && (busy_fall || !post_mode)),
        .full_q    (q_full),
        .addr_q    (q_addr),
        .data_q    (q_data)
    );

    // Flash write port: drain on busy fall, else immediate stores
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_wr_q      <= 1'b0;
            flash_wr_addr_q <= '0;
            flash_wr_data_q <= 8'h00;
        end else if (q_full && (busy_fall || !post_mode)) begin
            flash_wr_q      <= 1'b1;
            flash_wr_addr_q <= q_addr;
            flash_wr_data_q <= q_data;
        end else if (flash_store && !post_mode && !q_full) begin
            flash_wr_q      <= 1'b1;
            flash_wr_addr_q <= store_addr;
            flash_wr_data_q <= xdata_acc;
        end else begin
            flash_wr_q      <= 1'b0;
        end
    end

    // Pending flag mirrors queue occupancy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            posted_write_pending_q <= 1'b0;
        end else begin
            posted_write_pending_q <= q_full;
        end
    end

    // Read data; write-only fields read as zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_q <= 8'h00;
            if (sfr_addr == FEBP_FLASH_CTL_ADDR) begin
                sfr_rdata_q[FEBP_PWE_BIT]   <= program_write_enable_q;
                sfr_rdata_q[FEBP_PSTWR_BIT] <= posted_write_enable_q;
                sfr_rdata_q[FEBP_PEND_BIT]  <= q_full;
            end else if (sfr_addr == FEBP_BANK_ADDR) begin
                sfr_rdata_q[1:0] <= upper_bank_select_q;
            end
        end
    end
endmodule : febp_ctrl

/* febp_ctrl_properties.sv */
/* Port checker for febp_ctrl.
   Assumes binding onto every febp_ctrl instance. */
`timescale 1ns/1ps
module febp_ctrl_properties (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        irq_global_en,
    input wire logic        debug_port_en,
    input wire logic [3:0]  flash_unlock_key,
    input wire logic [15:0] prog_addr,
    input wire logic [16:0] flash_addr_q,
    input wire logic        xdata_store,
    input wire logic [7:0]  xdata_acc,
    input wire logic        ce_enable,
    input wire logic        ce_busy,
    input wire logic        flash_wr_q,
    input wire logic [7:0]  flash_wr_data_q,
    input wire logic        page_erase_q,
    input wire logic        mass_erase_q,
    input wire logic        program_write_enable_q,
    input wire logic        posted_write_pending_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    lower_map_a: assert property (!prog_addr[15] |=> flash_addr_q == {2'h0, $past(prog_addr[14:0])})
        else $error("lower window mapped wrong");
    bad_cmd_a: assert property (sfr_wr && sfr_addr == 8'h94 && sfr_wdata != 8'h55
        && sfr_wdata != 8'haa |=> !page_erase_q && !mass_erase_q) else $error("stray erase");
    page_key_a: assert property (page_erase_q |-> $past(sfr_wdata) == 8'h55
        && $past(flash_unlock_key) == 4'h2) else $error("page erase without cause");
    mass_dbg_a: assert property (mass_erase_q |-> $past(debug_port_en)
        && $past(sfr_wdata) == 8'haa) else $error("mass erase without cause");
    pwe_block_a: assert property (sfr_wr && sfr_addr == 8'hb2 && irq_global_en
        && !program_write_enable_q |=> !program_write_enable_q) else $error("pwe set with irq");
    pwe_clear_a: assert property (xdata_store && program_write_enable_q && !sfr_wr
        |=> !program_write_enable_q) else $error("pwe not cleared");
    imm_write_a: assert property (xdata_store && program_write_enable_q && !ce_enable
        && flash_unlock_key == 4'h2 && !posted_write_pending_q
        |=> flash_wr_q && flash_wr_data_q == $past(xdata_acc)) else $error("no immediate write");
    hold_busy_a: assert property (posted_write_pending_q && ce_busy |=> !flash_wr_q)
        else $error("write during busy");
    drain_a: assert property (posted_write_pending_q && $fell(ce_busy) |=> flash_wr_q)
        else $error("queue not drained");
endmodule : febp_ctrl_properties

bind febp_ctrl febp_ctrl_properties chk_u (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .irq_global_en(irq_global_en),
    .debug_port_en(debug_port_en), .flash_unlock_key(flash_unlock_key),
    .prog_addr(prog_addr), .flash_addr_q(flash_addr_q), .xdata_store(xdata_store),
    .xdata_acc(xdata_acc), .ce_enable(ce_enable), .ce_busy(ce_busy),
    .flash_wr_q(flash_wr_q), .flash_wr_data_q(flash_wr_data_q), .page_erase_q(page_erase_q),
    .mass_erase_q(mass_erase_q), .program_write_enable_q(program_write_enable_q),
    .posted_write_pending_q(posted_write_pending_q));

/* febp_flash_model.sv */
/* Flash array and compute engine busy model.
   Assumes one-cycle write and erase pulses on clk. */
`timescale 1ns/1ps
module febp_flash_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       busy_hold,
    input  wire logic       flash_wr_q,
    input  wire logic [7:0] flash_wr_data_q,
    input  wire logic       page_erase_q,
    input  wire logic       mass_erase_q,
    input  wire logic [5:0] erase_page_q,
    output logic            ce_busy,
    output int              wr_cnt,
    output int              pe_cnt,
    output int              me_cnt,
    output logic [7:0]      last_data,
    output logic [5:0]      last_page
);
    // Busy follows the request; the array logs every pulse
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_busy <= 1'b0;
            {wr_cnt, pe_cnt, me_cnt} <= '0;
            last_data <= 8'h00;
            last_page <= 6'h00;
        end else begin
            ce_busy <= busy_hold;
            if (flash_wr_q) begin
                wr_cnt <= wr_cnt + 1;
                last_data <= flash_wr_data_q;
            end
            if (page_erase_q) begin
                pe_cnt <= pe_cnt + 1;
                last_page <= erase_page_q;
            end
            if (mass_erase_q) me_cnt <= me_cnt + 1;
        end
    end
endmodule : febp_flash_model

/* tb.sv */
/* Self-checking bench for febp_ctrl.
   Assumes febp_pkg, model and checker compiled first. */
`timescale 1ns/1ps
module tb;
    import febp_pkg::*;
    logic        clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, irq = 0, dbg = 0, st = 0;
    logic        ce_en = 0, busy_hold = 0, ce_busy, wr_p, pe_p, me_p, pwe_q, pend_q;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0, acc = 0, rdata, wr_data, last_data;
    logic [3:0]  key = 0;
    logic [15:0] prog_addr = 0, ptr = 0;
    logic [16:0] faddr, wr_addr;
    logic [5:0]  epage, last_page;
    int          wr_cnt, pe_cnt, me_cnt, err_total = 0, checked = 0, cyc = 0, b;
    always #20 clk = ~clk;
    febp_ctrl dut_u (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(rdata), .irq_global_en(irq),
        .debug_port_en(dbg), .flash_unlock_key(key), .prog_addr(prog_addr),
        .flash_addr_q(faddr), .xdata_store(st), .xdata_ptr(ptr), .xdata_acc(acc),
        .ce_enable(ce_en), .ce_busy(ce_busy), .flash_wr_q(wr_p), .flash_wr_addr_q(wr_addr),
        .flash_wr_data_q(wr_data), .page_erase_q(pe_p), .mass_erase_q(me_p),
        .erase_page_q(epage), .program_write_enable_q(pwe_q), .posted_write_pending_q(pend_q));
    febp_flash_model mdl_u (.clk(clk), .rst_b(rst_b), .busy_hold(busy_hold), .flash_wr_q(wr_p),
        .flash_wr_data_q(wr_data), .page_erase_q(pe_p), .mass_erase_q(me_p),
        .erase_page_q(epage), .ce_busy(ce_busy), .wr_cnt(wr_cnt), .pe_cnt(pe_cnt),
        .me_cnt(me_cnt), .last_data(last_data), .last_page(last_page));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
        @(posedge clk) sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {sfr_rd, sfr_addr} <= {1'b1, a};
        @(posedge clk) sfr_rd <= 1'b0;
        tick(1);
        chk("sfr read", e, rdata);
    endtask : rd
    task automatic store(input logic [7:0] d);
        @(posedge clk) {st, ptr, acc} <= {1'b1, 16'h0010, d};
        @(posedge clk) st <= 1'b0;
        tick(3);
    endtask : store
    task automatic stop_test;
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // Hang guard
    always @(posedge clk) if (++cyc == 3000) begin
        err_total++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(FEBP_BANK_ADDR, 8'h01);
        rd(FEBP_FLASH_CTL_ADDR, 8'h00);
        rd(FEBP_ERASE_CMD_ADDR, 8'h00);
        for (b = 0; b < 4; b++) begin
            wr(FEBP_BANK_ADDR, 8'(b));
            @(posedge clk) prog_addr <= 16'h1234;
            tick(2);
            chk("lower map", 32'h01234, faddr);
            @(posedge clk) prog_addr <= 16'h9234;
            tick(2);
            chk("upper map", {15'h0, (b == 0) ? 2'h0 : 2'(b), 15'h1234}, faddr);
        end
        @(posedge clk) {key, dbg} <= {4'h2, 1'b1};
        wr(FEBP_ERASE_CMD_ADDR, 8'h55);
        wr(FEBP_PAGE_ADDR, 8'hfc);
        wr(FEBP_ERASE_CMD_ADDR, 8'h55);
        wr(FEBP_ERASE_CMD_ADDR, 8'h55);
        wr(FEBP_ERASE_CMD_ADDR, 8'h5a);
        wr(FEBP_ERASE_CMD_ADDR, 8'haa);
        tick(3);
        chk("page erases", 1, pe_cnt);
        chk("page number", 63, last_page);
        chk("mass erases", 0, me_cnt);
        wr(FEBP_FLASH_CTL_ADDR, 8'h02);
        wr(FEBP_ERASE_CMD_ADDR, 8'haa);
        wr(FEBP_ERASE_CMD_ADDR, 8'haa);
        @(posedge clk) dbg <= 1'b0;
        wr(FEBP_FLASH_CTL_ADDR, 8'h02);
        wr(FEBP_ERASE_CMD_ADDR, 8'haa);
        @(posedge clk) key <= 4'h3;
        wr(FEBP_PAGE_ADDR, 8'h04);
        wr(FEBP_ERASE_CMD_ADDR, 8'h55);
        wr(FEBP_FLASH_CTL_ADDR, 8'h01);
        store(8'h77);
        chk("mass erases", 1, me_cnt);
        chk("locked erase", 1, pe_cnt);
        chk("locked write", 0, wr_cnt);
        @(posedge clk) key <= 4'h2;
        wr(FEBP_FLASH_CTL_ADDR, 8'h01);
        store(8'h5c);
        chk("write data", 8'h5c, last_data);
        chk("write addr", 32'h00010, wr_addr);
        chk("pwe cleared", 0, pwe_q);
        rd(FEBP_FLASH_CTL_ADDR, 8'h00);
        @(posedge clk) irq <= 1'b1;
        wr(FEBP_FLASH_CTL_ADDR, 8'h01);
        rd(FEBP_FLASH_CTL_ADDR, 8'h00);
        @(posedge clk) {irq, ce_en, busy_hold} <= 3'b011;
        wr(FEBP_FLASH_CTL_ADDR, 8'h05);
        store(8'ha7);
        chk("pending flag", 1, pend_q);
        rd(FEBP_FLASH_CTL_ADDR, 8'h0c);
        wr(FEBP_FLASH_CTL_ADDR, 8'h05);
        store(8'h11);
        chk("held write", 1, wr_cnt);
        @(posedge clk) busy_hold <= 1'b0;
        tick(4);
        chk("drained data", 8'ha7, last_data);
        rd(FEBP_FLASH_CTL_ADDR, 8'h04);
        @(posedge clk) ce_en <= 1'b0;
        wr(FEBP_FLASH_CTL_ADDR, 8'h05);
        store(8'h3c);
        chk("ce off write", 8'h3c, last_data);
        chk("write count", 3, wr_cnt);
        @(posedge clk) ce_en <= 1'b1;
        wr(FEBP_FLASH_CTL_ADDR, 8'h01);
        store(8'h42);
        chk("post off write", 8'h42, last_data);
        chk("post off count", 4, wr_cnt);
        chk("pending idle", 0, pend_q);
        stop_test;
    end
endmodule : tb
